// ===== inc/fsc_pkg.sv
// constants, screen type and shared helper functions of the settings menu
package fsc_pkg;
   // system clock and the derived timing counts
   localparam int CLK_HZ = 10_000_000;
   localparam int HOLD_S = 6;                 // navigate hold to enter menu
   localparam int HOLD_CYC = HOLD_S * CLK_HZ;
   localparam int INHIBIT_S = 60;             // alarm hold-off after exit
   localparam int INHIBIT_CYC = INHIBIT_S * CLK_HZ;
   localparam int DEB_MS = 10;                // button settle time
   localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 30;                 // holds INHIBIT_CYC

   // bus node address
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hf7;
   localparam logic [7:0] ADDR_DEF = 8'h01;

   // baud selection index 0..6 = 110..19200 bps
   localparam int BAUD_W = 3;
   localparam logic [2:0] BAUD_MIN = 3'h0;
   localparam logic [2:0] BAUD_MAX = 3'h6;
   localparam logic [2:0] BAUD_DEF = 3'h5;
   localparam int DIV_W = 17;

   // fixed 8-N-1 framing
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [1:0] PARITY_NONE = 2'h0;
   localparam logic [1:0] STOP_BITS = 2'h1;

   // analog trims in units of 10 uA
   localparam int TRIM_W = 12;
   localparam logic [11:0] TRIM_MIN = 12'h000;
   localparam logic [11:0] TRIM_MAX = 12'h960;  // 24.00 mA
   localparam logic [11:0] ZERO_DEF = 12'h190;  // 4.00 mA
   localparam logic [11:0] FULL_DEF = 12'h7d0;  // 20.00 mA

   // display contrast
   localparam int CON_W = 7;
   localparam logic [6:0] CON_MIN = 7'h01;
   localparam logic [6:0] CON_MAX = 7'h40;
   localparam logic [6:0] CON_DEF = 7'h1d;

   // response word
   localparam int WORD_BYTES = 4;
   localparam logic [1:0] LAST_BYTE = 2'h3;

   typedef enum logic [2:0] {
      ST_NORMAL, ST_ADDR, ST_BAUD, ST_AOUT, ST_ZERO, ST_FULL, ST_CONTRAST
   } fsc_screen_type;

   // one saturating step, shared by every adjustable setting
   function automatic logic [11:0] sat_step(input logic [11:0] v,
         input logic [11:0] lo, input logic [11:0] hi,
         input logic up, input logic dn);
      logic [11:0] r;
      r = v;
      if (up && v < hi) begin
         r = v + 12'h001;
      end else if (dn && v > lo) begin
         r = v - 12'h001;
      end
      return r;
   endfunction : sat_step

   // clock cycles per bit for each baud index
   function automatic logic [16:0] baud_div(input logic [2:0] idx);
      int rate;
      rate = 9600;
      case (idx)
         3'h0: rate = 110;
         3'h1: rate = 300;
         3'h2: rate = 1200;
         3'h3: rate = 2400;
         3'h4: rate = 4800;
         3'h5: rate = 9600;
         default: rate = 19200;
      endcase
      return 17'(CLK_HZ / rate);
   endfunction : baud_div
endpackage : fsc_pkg

// ===== logic/fsc_button.sv
// debounced push button with a one-cycle release pulse
`timescale 1ns/1ps
module fsc_button #(
   parameter int DEB_CYC = fsc_pkg::DEB_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic btn_raw,
   output logic level,
   output logic released
);
   logic level_reg, level_next;
   logic rel_reg, rel_next;
   logic [fsc_pkg::CNT_W-1:0] cnt_reg, cnt_next;

   // a change must persist for the whole settle time to be accepted,
   // so contact bounce never yields a second step
   always_comb begin
      level_next = level_reg;
      rel_next = 1'b0;
      cnt_next = '0;
      if (btn_raw != level_reg) begin
         cnt_next = cnt_reg + 1'b1;
         if (cnt_reg == fsc_pkg::CNT_W'(DEB_CYC - 1)) begin
            level_next = btn_raw;
            rel_next = level_reg;  // R22
            cnt_next = '0;
         end
      end
   end

   // register the debounce state
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         level_reg <= 1'b0;
         rel_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         level_reg <= level_next;
         rel_reg <= rel_next;
         cnt_reg <= cnt_next;
      end
   end

   assign level = level_reg;
   assign released = rel_reg;
endmodule : fsc_button

// ===== logic/fsc_poll_resp.sv
// poll address filter and lsb-first response byte sender
`timescale 1ns/1ps
module fsc_poll_resp (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] node_addr,
   input wire logic [7:0] rx_addr,
   input wire logic rx_addr_valid,
   input wire logic [31:0] resp_word,
   input wire logic tx_ready,
   output logic poll_accept,
   output logic [7:0] tx_byte,
   output logic tx_valid
);
   typedef enum logic {RS_IDLE, RS_SEND} fsc_resp_type;
   fsc_resp_type st_reg, st_next;
   logic acc_reg, acc_next;
   logic [31:0] word_reg, word_next;
   logic [1:0] idx_reg, idx_next;
   logic [7:0] byte_reg, byte_next;
   logic val_reg, val_next;

   // frames for other nodes and polls that arrive mid-answer are dropped
   always_comb begin
      st_next = st_reg;
      acc_next = 1'b0;
      word_next = word_reg;
      idx_next = idx_reg;
      byte_next = byte_reg;
      val_next = val_reg;
      case (st_reg)
         RS_IDLE: begin
            if (rx_addr_valid && rx_addr == node_addr) begin  // R05
               acc_next = 1'b1;
               word_next = resp_word;
               idx_next = '0;
               byte_next = resp_word[7:0];  // R08
               val_next = 1'b1;  // R06
               st_next = RS_SEND;
            end
         end
         default: begin
            if (tx_ready) begin
               if (idx_reg == fsc_pkg::LAST_BYTE) begin
                  val_next = 1'b0;
                  st_next = RS_IDLE;
               end else begin
                  idx_next = idx_reg + 2'h1;
                  byte_next = word_reg[8*(idx_reg+2'h1) +: 8];  // R08
               end
            end
         end
      endcase
   end

   // register the responder state
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= RS_IDLE;
         acc_reg <= 1'b0;
         word_reg <= '0;
         idx_reg <= '0;
         byte_reg <= '0;
         val_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         acc_reg <= acc_next;
         word_reg <= word_next;
         idx_reg <= idx_next;
         byte_reg <= byte_next;
         val_reg <= val_next;
      end
   end

   assign poll_accept = acc_reg;
   assign tx_byte = byte_reg;
   assign tx_valid = val_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   property p_addr_match;
      poll_accept |-> $past(rx_addr) == $past(node_addr);
   endproperty
   a_addr_match: assert property (p_addr_match) // R05
      else $error("poll accepted for a foreign address");

   property p_lsb_first;
      poll_accept |-> tx_valid && tx_byte == word_reg[7:0];
   endproperty
   a_lsb_first: assert property (p_lsb_first) // R08
      else $error("response did not start with the low byte");

   property p_answer_after_poll;
      $rose(tx_valid) |-> poll_accept;
   endproperty
   a_answer_after_poll: assert property (p_answer_after_poll) // R06
      else $error("response without a decoded poll");

   c_poll: cover property (poll_accept ##1 tx_valid && tx_ready);
endmodule : fsc_poll_resp

// ===== logic/fsc_menu.sv
// field settings menu: buttons, serial settings, trims, contrast
// Operation
// R01 - menu opens only after navigate held six seconds in normal mode
// R02 - each navigate release advances to the next screen in fixed order
// R03 - increment raises, decrement lowers the node address by one
// R04 - node address is limited to 1 through 247
// R05 - only frames addressed to the stored node address are accepted
// R06 - master polls first; device decodes, then answers with data
// R07 - framing is fixed at eight data bits, no parity, one stop
// R08 - float values go out least significant byte first
// R09 - node address initialises to one
// R10 - baud choices are 110, 300, 1200, 2400, 4800, 9600, 19200
// R11 - baud selection initialises to 9600
// R12 - buttons step the preset baud rates; master must match it
// R13 - trim screen: increment opens zero trim, others skip to contrast
// R14 - zero trim adjusts by buttons; navigate stores it, goes full-scale
// R15 - full-scale trim adjusts; navigate stores it, goes to contrast
// R16 - output forced to full scale while full-scale trim is edited
// R17 - trims initialise to 4.00 mA and 20.00 mA
// R18 - contrast spans 1 to 64, default 29; up brightens
// R19 - navigate from the last screen returns to normal operation
// R20 - alarms held off about one minute after leaving the menu
// R21 - address, contrast and baud saturate at their range ends
// R22 - each press is debounced and counted once, on release
`timescale 1ns/1ps
module fsc_menu #(
   parameter int HOLD_CYC = fsc_pkg::HOLD_CYC,
   parameter int INHIBIT_CYC = fsc_pkg::INHIBIT_CYC,
   parameter int DEB_CYC = fsc_pkg::DEB_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic nav_btn,
   input wire logic inc_btn,
   input wire logic dec_btn,
   input wire logic [7:0] rx_addr,
   input wire logic rx_addr_valid,
   input wire logic [31:0] resp_word,
   input wire logic tx_ready,
   output fsc_pkg::fsc_screen_type screen,
   output logic in_menu,
   output logic [7:0] node_addr,
   output logic [2:0] baud_sel,
   output logic [16:0] baud_div,
   output logic [3:0] data_bits,
   output logic [1:0] parity_mode,
   output logic [1:0] stop_bits,
   output logic [11:0] aout_zero,
   output logic [11:0] aout_full,
   output logic aout_force_full,
   output logic [6:0] contrast,
   output logic alarm_inhibit,
   output logic poll_accept,
   output logic [7:0] tx_byte,
   output logic tx_valid
);
   logic nav_level, nav_rel, inc_rel, dec_rel;
   fsc_pkg::fsc_screen_type st_reg, st_next;
   logic swallow_reg, swallow_next;
   logic [fsc_pkg::CNT_W-1:0] hold_reg, hold_next;
   logic [fsc_pkg::CNT_W-1:0] inh_reg, inh_next;
   logic [7:0] addr_reg, addr_next;
   logic [2:0] baud_reg, baud_next;
   logic [16:0] div_reg, div_next;
   logic [11:0] zero_reg, zero_next, full_reg, full_next;
   logic [11:0] edit_reg, edit_next;
   logic [11:0] zout_reg, zout_next, fout_reg, fout_next;
   logic force_reg, force_next;
   logic [6:0] con_reg, con_next;
   logic menu_reg, menu_next;
   logic alarm_reg, alarm_next;
   logic [3:0] dbits_reg;
   logic [1:0] par_reg, stop_reg;

   // the three front-panel buttons
   fsc_button #(.DEB_CYC(DEB_CYC)) u_nav (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .btn_raw(nav_btn),
      .level(nav_level), .released(nav_rel));
   fsc_button #(.DEB_CYC(DEB_CYC)) u_inc (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .btn_raw(inc_btn),
      .level(), .released(inc_rel));
   fsc_button #(.DEB_CYC(DEB_CYC)) u_dec (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .btn_raw(dec_btn),
      .level(), .released(dec_rel));

   // serial poll filter and response sender
   fsc_poll_resp u_resp (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .node_addr(addr_reg),
      .rx_addr(rx_addr), .rx_addr_valid(rx_addr_valid),
      .resp_word(resp_word), .tx_ready(tx_ready),
      .poll_accept(poll_accept), .tx_byte(tx_byte), .tx_valid(tx_valid));

   // screen walk and setting edits; trims are edited in a scratch copy
   // and only committed on navigate, so a half-made trim is never kept
   always_comb begin
      st_next = st_reg;
      swallow_next = swallow_reg;
      hold_next = '0;
      addr_next = addr_reg;
      baud_next = baud_reg;
      zero_next = zero_reg;
      full_next = full_reg;
      edit_next = edit_reg;
      con_next = con_reg;
      inh_next = inh_reg;
      if (inh_reg != '0) begin
         inh_next = inh_reg - 1'b1;
      end
      if (st_reg == fsc_pkg::ST_NORMAL) begin
         if (nav_level && !swallow_reg) begin
            hold_next = hold_reg + 1'b1;
            if (hold_reg == fsc_pkg::CNT_W'(HOLD_CYC - 1)) begin  // R01
               st_next = fsc_pkg::ST_ADDR;
               swallow_next = 1'b1;  // release of the long hold is no step
               hold_next = '0;
            end
         end
         if (nav_rel) begin
            swallow_next = 1'b0;
         end
      end else if (swallow_reg && nav_rel) begin
         swallow_next = 1'b0;
      end else begin
         case (st_reg)
            fsc_pkg::ST_ADDR: begin
               addr_next = 8'(fsc_pkg::sat_step(12'(addr_reg),
                  12'(fsc_pkg::ADDR_MIN), 12'(fsc_pkg::ADDR_MAX),
                  inc_rel, dec_rel));  // R03 R04 R21
               if (nav_rel) begin
                  st_next = fsc_pkg::ST_BAUD;  // R02
               end
            end
            fsc_pkg::ST_BAUD: begin
               baud_next = 3'(fsc_pkg::sat_step(12'(baud_reg),
                  12'(fsc_pkg::BAUD_MIN), 12'(fsc_pkg::BAUD_MAX),
                  inc_rel, dec_rel));  // R10 R12 R21
               if (nav_rel) begin
                  st_next = fsc_pkg::ST_AOUT;
               end
            end
            fsc_pkg::ST_AOUT: begin
               if (inc_rel) begin
                  st_next = fsc_pkg::ST_ZERO;  // R13
                  edit_next = zero_reg;
               end else if (dec_rel || nav_rel) begin
                  st_next = fsc_pkg::ST_CONTRAST;  // R13
               end
            end
            fsc_pkg::ST_ZERO: begin
               edit_next = fsc_pkg::sat_step(edit_reg, fsc_pkg::TRIM_MIN,
                  fsc_pkg::TRIM_MAX, inc_rel, dec_rel);  // R14
               if (nav_rel) begin
                  zero_next = edit_reg;  // R14
                  edit_next = full_reg;
                  st_next = fsc_pkg::ST_FULL;
               end
            end
            fsc_pkg::ST_FULL: begin
               edit_next = fsc_pkg::sat_step(edit_reg, fsc_pkg::TRIM_MIN,
                  fsc_pkg::TRIM_MAX, inc_rel, dec_rel);  // R15
               if (nav_rel) begin
                  full_next = edit_reg;  // R15
                  st_next = fsc_pkg::ST_CONTRAST;
               end
            end
            default: begin
               con_next = 7'(fsc_pkg::sat_step(12'(con_reg),
                  12'(fsc_pkg::CON_MIN), 12'(fsc_pkg::CON_MAX),
                  inc_rel, dec_rel));  // R18 R21
               if (nav_rel) begin
                  st_next = fsc_pkg::ST_NORMAL;  // R19
                  inh_next = fsc_pkg::CNT_W'(INHIBIT_CYC);  // R20
               end
            end
         endcase
      end
      // outputs follow the live edit so the loop can be trimmed by eye
      zout_next = (st_next == fsc_pkg::ST_ZERO) ? edit_next : zero_next;
      fout_next = (st_next == fsc_pkg::ST_FULL) ? edit_next : full_next;
      force_next = (st_next == fsc_pkg::ST_FULL);  // R16
      menu_next = (st_next != fsc_pkg::ST_NORMAL);
      alarm_next = menu_next || inh_next != '0;  // R20
      div_next = fsc_pkg::baud_div(baud_next);  // R10
   end

   // register the menu state; reset is the factory initialisation
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= fsc_pkg::ST_NORMAL;
         swallow_reg <= 1'b0;
         hold_reg <= '0;
         inh_reg <= '0;
         addr_reg <= fsc_pkg::ADDR_DEF;  // R09
         baud_reg <= fsc_pkg::BAUD_DEF;  // R11
         div_reg <= fsc_pkg::baud_div(fsc_pkg::BAUD_DEF);
         zero_reg <= fsc_pkg::ZERO_DEF;  // R17
         full_reg <= fsc_pkg::FULL_DEF;  // R17
         edit_reg <= fsc_pkg::ZERO_DEF;
         zout_reg <= fsc_pkg::ZERO_DEF;
         fout_reg <= fsc_pkg::FULL_DEF;
         force_reg <= 1'b0;
         con_reg <= fsc_pkg::CON_DEF;  // R18
         menu_reg <= 1'b0;
         alarm_reg <= 1'b0;
         dbits_reg <= fsc_pkg::DATA_BITS;  // R07
         par_reg <= fsc_pkg::PARITY_NONE;  // R07
         stop_reg <= fsc_pkg::STOP_BITS;  // R07
      end else begin
         st_reg <= st_next;
         swallow_reg <= swallow_next;
         hold_reg <= hold_next;
         inh_reg <= inh_next;
         addr_reg <= addr_next;
         baud_reg <= baud_next;
         div_reg <= div_next;
         zero_reg <= zero_next;
         full_reg <= full_next;
         edit_reg <= edit_next;
         zout_reg <= zout_next;
         fout_reg <= fout_next;
         force_reg <= force_next;
         con_reg <= con_next;
         menu_reg <= menu_next;
         alarm_reg <= alarm_next;
         dbits_reg <= fsc_pkg::DATA_BITS;  // no way to change the framing
         par_reg <= fsc_pkg::PARITY_NONE;
         stop_reg <= fsc_pkg::STOP_BITS;
      end
   end

   // every output straight from its register
   assign screen = st_reg;
   assign in_menu = menu_reg;
   assign node_addr = addr_reg;
   assign baud_sel = baud_reg;
   assign baud_div = div_reg;
   assign data_bits = dbits_reg;
   assign parity_mode = par_reg;
   assign stop_bits = stop_reg;
   assign aout_zero = zout_reg;
   assign aout_full = fout_reg;
   assign aout_force_full = force_reg;
   assign contrast = con_reg;
   assign alarm_inhibit = alarm_reg;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   property p_enter_hold;
      st_reg == fsc_pkg::ST_NORMAL && st_next != fsc_pkg::ST_NORMAL
         |-> nav_level && hold_reg == fsc_pkg::CNT_W'(HOLD_CYC - 1);
   endproperty
   a_enter_hold: assert property (p_enter_hold) // R01
      else $error("menu entered without a full hold");

   property p_addr_range;
      node_addr >= fsc_pkg::ADDR_MIN && node_addr <= fsc_pkg::ADDR_MAX;
   endproperty
   a_addr_range: assert property (p_addr_range) // R04
      else $error("node address out of range");

   property p_addr_inc;
      st_reg == fsc_pkg::ST_ADDR && !swallow_reg && inc_rel
         && addr_reg < fsc_pkg::ADDR_MAX
         |=> addr_reg == $past(addr_reg) + 8'h01;
   endproperty
   a_addr_inc: assert property (p_addr_inc) // R03
      else $error("address did not rise by one");

   property p_baud_range;
      baud_sel <= fsc_pkg::BAUD_MAX
         && baud_div == fsc_pkg::baud_div(baud_sel);
   endproperty
   a_baud_range: assert property (p_baud_range) // R10
      else $error("baud selection outside the preset list");

   property p_con_range;
      contrast >= fsc_pkg::CON_MIN && contrast <= fsc_pkg::CON_MAX;
   endproperty
   a_con_range: assert property (p_con_range) // R18
      else $error("contrast out of range");

   property p_force_full;
      aout_force_full == (screen == fsc_pkg::ST_FULL);
   endproperty
   a_force_full: assert property (p_force_full) // R16
      else $error("full-scale force does not track the trim screen");

   property p_inhibit_after_exit;
      $fell(in_menu) |-> alarm_inhibit ##1 alarm_inhibit[*8];
   endproperty
   a_inhibit_after_exit: assert property (p_inhibit_after_exit) // R20
      else $error("alarms released right after leaving the menu");

   property p_addr_to_baud;
      st_reg == fsc_pkg::ST_ADDR && !swallow_reg && nav_rel
         |=> st_reg == fsc_pkg::ST_BAUD ##1 screen == fsc_pkg::ST_BAUD;
   endproperty
   a_addr_to_baud: assert property (p_addr_to_baud) // R02
      else $error("navigate did not advance from the address screen");

   property p_framing;
      data_bits == 4'h8 && parity_mode == 2'h0 && stop_bits == 2'h1;
   endproperty
   a_framing: assert property (p_framing) // R07
      else $error("serial framing is not 8-N-1");

   c_enter: cover property ($rose(in_menu));
   c_full_commit: cover property (st_reg == fsc_pkg::ST_FULL
      ##1 st_reg == fsc_pkg::ST_CONTRAST);
   c_exit: cover property ($fell(in_menu));
endmodule : fsc_menu

// ===== testbench/fsc_master_model.sv
// serial master model: issues polls and collects response bytes
`timescale 1ns/1ps
module fsc_master_model (
   input wire logic sys_clk,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   output logic [7:0] rx_addr,
   output logic rx_addr_valid,
   output logic tx_ready
);
   logic slow = 1'b0;
   logic [31:0] got = 32'h0;
   int got_n = 0;

   initial begin
      rx_addr = 8'h00;
      rx_addr_valid = 1'b0;
   end

   // a slow master stalls every other cycle, a prompt one never does
   // a new frame clears the byte count, so each poll is counted afresh
   always @(posedge sys_clk) begin
      if (rx_addr_valid) begin
         got_n <= 0;
      end else if (tx_valid && tx_ready) begin
         got <= {tx_byte, got[31:8]};
         got_n <= got_n + 1;
      end
      tx_ready <= #1 slow ? ~tx_ready : 1'b1;
   end

   // one poll frame; the stale address field is scrambled afterwards
   task automatic poll(input logic [7:0] a);
      @(posedge sys_clk);
      #1 rx_addr = a;
      rx_addr_valid = 1'b1;
      @(posedge sys_clk);
      #1 rx_addr_valid = 1'b0;
      rx_addr = ~a;
   endtask : poll
endmodule : fsc_master_model

// ===== testbench/field_settings_menu_serial_cfg_tb.sv
// self-checking bench for the settings menu and poll responder
`timescale 1ns/1ps
module field_settings_menu_serial_cfg_tb;
   logic sys_clk = 1'b0;
   logic sys_rst;
   logic nav_btn, inc_btn, dec_btn;
   logic [7:0] rx_addr;
   logic rx_addr_valid, tx_ready;
   logic [31:0] resp_word;
   fsc_pkg::fsc_screen_type screen;
   logic in_menu, aout_force_full, alarm_inhibit, poll_accept, tx_valid;
   logic [7:0] node_addr, tx_byte;
   logic [2:0] baud_sel;
   logic [16:0] baud_div;
   logic [3:0] data_bits;
   logic [1:0] parity_mode, stop_bits;
   logic [11:0] aout_zero, aout_full;
   logic [6:0] contrast;
   int num_errors = 0;
   int num_checks = 0;
   int i;
   int rates[7] = '{110, 300, 1200, 2400, 4800, 9600, 19200};

   always #50 sys_clk = ~sys_clk;

   // short counts keep the hold and hold-off phases brief
   fsc_menu #(.HOLD_CYC(20), .INHIBIT_CYC(30), .DEB_CYC(3)) fsc_menu_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .nav_btn(nav_btn),
      .inc_btn(inc_btn), .dec_btn(dec_btn), .rx_addr(rx_addr),
      .rx_addr_valid(rx_addr_valid), .resp_word(resp_word),
      .tx_ready(tx_ready), .screen(screen), .in_menu(in_menu),
      .node_addr(node_addr), .baud_sel(baud_sel), .baud_div(baud_div),
      .data_bits(data_bits), .parity_mode(parity_mode),
      .stop_bits(stop_bits), .aout_zero(aout_zero), .aout_full(aout_full),
      .aout_force_full(aout_force_full), .contrast(contrast),
      .alarm_inhibit(alarm_inhibit), .poll_accept(poll_accept),
      .tx_byte(tx_byte), .tx_valid(tx_valid));

   fsc_master_model fsc_master_model_inst (
      .sys_clk(sys_clk), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .rx_addr(rx_addr), .rx_addr_valid(rx_addr_valid),
      .tx_ready(tx_ready));

   task automatic summarize();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // hold buttons {nav, inc, dec} for h cycles, then let release settle
   task automatic press(input logic [2:0] b, input int h);
      {nav_btn, inc_btn, dec_btn} = b;
      tick(h);
      {nav_btn, inc_btn, dec_btn} = 3'h0;
      tick(8);
   endtask : press

   task automatic scr(input fsc_pkg::fsc_screen_type s);
      check("screen", 32'(screen), 32'(s));
   endtask : scr

   // waits a bounded time for the four response bytes
   task automatic collect(input logic [31:0] w);
      for (i = 0; i < 40 && fsc_master_model_inst.got_n < 4; i++) tick(1);
      check("bytes", 32'(fsc_master_model_inst.got_n), 32'h4);
      check("word", fsc_master_model_inst.got, w);
   endtask : collect

   // one poll to address a, with w as the data the device returns
   task automatic ask(input logic [7:0] a, input logic [31:0] w);
      resp_word = w;
      fsc_master_model_inst.poll(a);
   endtask : ask

   // watchdog: the whole run needs well under 20000 cycles
   initial begin
      #2_000_000;
      num_errors++;
      summarize();
   end

   initial begin
      {nav_btn, inc_btn, dec_btn} = 3'h0;
      sys_rst = 1'b1;
      tick(6);
      sys_rst = 1'b0;
      tick(1);
      scr(fsc_pkg::ST_NORMAL);
      check("node_addr", 32'(node_addr), 32'h1);
      check("baud_sel", 32'(baud_sel), 32'h5);
      check("baud_div", 32'(baud_div), 32'h411);
      check("frame", 32'({data_bits, parity_mode, stop_bits}), 32'h81);
      check("zero", 32'(aout_zero), 32'h190);
      check("full", 32'(aout_full), 32'h7d0);
      check("contrast", 32'(contrast), 32'h1d);
      check("idle", 32'({alarm_inhibit, tx_valid, aout_force_full}),
         32'h0);
      press(3'h4, 15);
      scr(fsc_pkg::ST_NORMAL);
      press(3'h4, 30);
      scr(fsc_pkg::ST_ADDR);
      check("menu", 32'({in_menu, alarm_inhibit}), 32'h3);
      press(3'h1, 6);
      check("node_addr", 32'(node_addr), 32'h1);
      press(3'h2, 2);
      check("node_addr", 32'(node_addr), 32'h1);
      press(3'h2, 6);
      check("node_addr", 32'(node_addr), 32'h2);
      press(3'h1, 6);
      check("node_addr", 32'(node_addr), 32'h1);
      for (int k = 0; k < 250; k++) press(3'h2, 4);
      check("node_addr", 32'(node_addr), 32'hf7);
      press(3'h4, 6);
      scr(fsc_pkg::ST_BAUD);
      press(3'h2, 6);
      press(3'h2, 6);
      for (int k = 6; k >= 0; k--) begin
         check("baud_sel", 32'(baud_sel), 32'(k));
         check("baud_div", 32'(baud_div), 32'(10000000 / rates[k]));
         press(3'h1, 6);
      end
      check("baud_sel", 32'(baud_sel), 32'h0);
      press(3'h4, 6);
      scr(fsc_pkg::ST_AOUT);
      press(3'h1, 6);
      scr(fsc_pkg::ST_CONTRAST);
      press(3'h2, 6);
      check("contrast", 32'(contrast), 32'h1e);
      press(3'h1, 6);
      press(3'h1, 6);
      check("contrast", 32'(contrast), 32'h1c);
      for (int k = 0; k < 40; k++) press(3'h2, 4);
      check("contrast", 32'(contrast), 32'h40);
      press(3'h4, 6);
      scr(fsc_pkg::ST_NORMAL);
      check("menu", 32'({in_menu, alarm_inhibit}), 32'h1);
      tick(20);
      check("inhibit", 32'(alarm_inhibit), 32'h1);
      tick(15);
      check("inhibit", 32'(alarm_inhibit), 32'h0);
      // second pass: navigate skips the trims
      press(3'h4, 30);
      press(3'h4, 6);
      press(3'h4, 6);
      press(3'h4, 6);
      scr(fsc_pkg::ST_CONTRAST);
      press(3'h4, 6);
      // third pass: increment opens the trims
      press(3'h4, 30);
      press(3'h4, 6);
      press(3'h4, 6);
      press(3'h2, 6);
      scr(fsc_pkg::ST_ZERO);
      press(3'h2, 6);
      check("zero", 32'(aout_zero), 32'h191);
      press(3'h4, 6);
      scr(fsc_pkg::ST_FULL);
      check("force", 32'(aout_force_full), 32'h1);
      press(3'h1, 6);
      check("full", 32'(aout_full), 32'h7cf);
      press(3'h4, 6);
      scr(fsc_pkg::ST_CONTRAST);
      check("trims", 32'({aout_force_full, aout_zero, aout_full}),
         32'h1917cf);
      press(3'h4, 6);
      check("node_addr", 32'(node_addr), 32'hf7);
      // serial polls: foreign address, then prompt and slow masters
      ask(8'h01, 32'h3f80_1234);
      check("accept", 32'(poll_accept), 32'h0);
      tick(10);
      check("refused", 32'(fsc_master_model_inst.got_n), 32'h0);
      ask(8'hf7, 32'h3f80_1234);
      check("accept", 32'(poll_accept), 32'h1);
      collect(32'h3f80_1234);
      fsc_master_model_inst.slow = 1'b1;
      tick(2);
      ask(8'hf7, 32'hc1a2_b3d4);
      check("accept", 32'(poll_accept), 32'h1);
      collect(32'hc1a2_b3d4);
      tick(2);
      check("tx_valid", 32'(tx_valid), 32'h0);
      // a mid-run reset must bring back the factory settings
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      tick(1);
      check("node_addr", 32'(node_addr), 32'h1);
      check("baud_sel", 32'(baud_sel), 32'h5);
      check("full", 32'(aout_full), 32'h7d0);
      check("contrast", 32'(contrast), 32'h1d);
      summarize();
   end
endmodule : field_settings_menu_serial_cfg_tb
